// ---- cbme_regs.svh ----
// register offsets, field positions, reset values and cycle counts of the exec unit
// Summary of operation
// RULE1: program memory read loads byte at Z, optional Z increment, no flags, 3 cycles
// RULE2: push writes source register to stack, flags unchanged, 2 cycles
// RULE3: pop loads destination register from stack, flags unchanged, 2 cycles
// RULE4: io bit set/clear forces one I/O bit to 1 or 0, no flags, 2 cycles
// RULE5: rotate left: carry into bit 0, bit 7 into carry, updates Z C N V, 1 cycle
// RULE6: rotate right: carry into bit 7, bit 0 into carry, updates Z C N V, 1 cycle
// RULE7: register bit copied into transfer flag only, 1 cycle
// RULE8: transfer flag copied into register bit, flags unchanged, 1 cycle
// RULE9: signed flag set/clear drives S only, 1 cycle
// RULE10: overflow flag set/clear drives V only, 1 cycle
// RULE11: half carry set/clear drives H only, 1 cycle
// RULE12: sleep enters sleep state, flags unchanged, 1 cycle
// RULE13: watchdog restart pulses restart, flags unchanged, 1 cycle
// RULE14: logical shifts insert 0, arithmetic right keeps bit 7, update Z C N V, 1 cycle
// RULE15: program memory write stores R1:R0 at Z, cycle count variable, no flags
// RULE16: port in/out moves one byte register to or from I/O, 1 cycle, no flags
`ifndef CBME_REGS_SVH
`define CBME_REGS_SVH
// byte addresses on the bus
`define CBME_ADDR_CMD 8'h00
`define CBME_ADDR_STATUS 8'h04
`define CBME_ADDR_FLAGS 8'h08
`define CBME_ADDR_REG_SEL 8'h0c
`define CBME_ADDR_REG_DATA 8'h10
`define CBME_ADDR_IO_SEL 8'h14
`define CBME_ADDR_IO_DATA 8'h18
`define CBME_ADDR_PM_SEL 8'h1c
`define CBME_ADDR_PM_DATA 8'h20
`define CBME_ADDR_STACK_PTR 8'h24
`define CBME_ADDR_WDR_COUNT 8'h28
// command word fields
`define CBME_CMD_OP_LSB 0
`define CBME_CMD_RD_LSB 5
`define CBME_CMD_IOA_LSB 10
`define CBME_CMD_BIT_LSB 16
// status word bits
`define CBME_STAT_BUSY 0
`define CBME_STAT_SLEEP 1
// status_flags_reg bit positions and reset value
`define CBME_FLAG_C 0
`define CBME_FLAG_Z 1
`define CBME_FLAG_N 2
`define CBME_FLAG_V 3
`define CBME_FLAG_S 4
`define CBME_FLAG_H 5
`define CBME_FLAG_T 6
`define CBME_FLAGS_RESET 8'h00
// execution cycle counts
`define CBME_CYC_PM_READ 8'h03
`define CBME_CYC_STACK 8'h02
`define CBME_CYC_IO_BIT 8'h02
`define CBME_CYC_SINGLE 8'h01
`endif

// ---- cbme_pkg.sv ----
// types of the exec unit: operation codes and sequencer states
package cbme_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_PM_READ_R0 = 5'h01, OP_PM_READ = 5'h02, OP_PM_READ_INC = 5'h03,
    OP_PM_WRITE = 5'h04, OP_PORT_IN = 5'h05, OP_PORT_OUT = 5'h06, OP_PUSH = 5'h07,
    OP_POP = 5'h08, OP_IO_BIT_SET = 5'h09, OP_IO_BIT_CLEAR = 5'h0a, OP_SHL_LOGICAL = 5'h0b,
    OP_SHR_LOGICAL = 5'h0c, OP_SHR_ARITH = 5'h0d, OP_ROT_LEFT_CARRY = 5'h0e,
    OP_ROT_RIGHT_CARRY = 5'h0f, OP_BIT_TO_TFLAG = 5'h10, OP_TFLAG_TO_BIT = 5'h11,
    OP_SIGNED_SET = 5'h12, OP_SIGNED_CLEAR = 5'h13, OP_OVF_SET = 5'h14, OP_OVF_CLEAR = 5'h15,
    OP_HALF_SET = 5'h16, OP_HALF_CLEAR = 5'h17, OP_SLEEP = 5'h18, OP_WDOG_RESTART = 5'h19
  } cbme_op_type;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} cbme_state_type;
endpackage

// ---- cbme_exec.sv ----
// exec unit for bit, shift, flag, stack, port and program memory operations
`timescale 1ns/10ps
`default_nettype none
`include "cbme_regs.svh"
module cbme_exec #(
  parameter int IO_DEPTH = 64,
  parameter int STACK_DEPTH = 16,
  parameter int PM_DEPTH = 64,
  parameter logic [7:0] PM_WRITE_CYCLES = 8'h04
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // core controls
  input wire logic WAKE,
  output logic SLEEP_REQ,
  output logic WDT_RESTART,
  output logic EXEC_DONE,
  output logic BUSY
);
  localparam int IOW = $clog2(IO_DEPTH);
  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int PMW = $clog2(PM_DEPTH);
  localparam logic [SPW-1:0] SP_ONE = SPW'(1);
  localparam logic [SPW-1:0] SP_TOP = SPW'(STACK_DEPTH - 1);

  typedef struct packed {
    cbme_pkg::cbme_state_type st;
    logic [7:0] cnt;
    cbme_pkg::cbme_op_type op;
    logic [4:0] rd;
    logic [5:0] ioa;
    logic [2:0] bsel;
    logic [31:0][7:0] regs;
    logic [IO_DEPTH-1:0][7:0] io;
    logic [STACK_DEPTH-1:0][7:0] stk;
    logic [SPW-1:0] sp;
    logic [PM_DEPTH-1:0][15:0] pm;
    logic [7:0] flags;
    logic [4:0] reg_sel;
    logic [IOW-1:0] io_sel;
    logic [PMW-1:0] pm_sel;
    logic wr_pend;
    logic rd_pend;
    logic rd_done;
    logic hit;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic sleep;
    logic watchdog_restart;
    logic done;
    logic [15:0] wdr_cnt;
  } cbme_state_s_type;

  cbme_state_s_type q;
  cbme_state_s_type n;
  cbme_pkg::cbme_op_type issue_op;
  logic issue;
  logic commit;
  logic [15:0] zp;
  logic [15:0] pmw;
  logic [7:0] pmb;
  logic [7:0] src;
  logic [7:0] sh;
  logic shc;
  logic is_sh;
  logic [31:0] rdmux;

  // cycles from acceptance to commit, per operation
  function automatic logic [7:0] op_cycles(input cbme_pkg::cbme_op_type op);
    case (op)
      cbme_pkg::OP_PM_READ_R0, cbme_pkg::OP_PM_READ, cbme_pkg::OP_PM_READ_INC: op_cycles = `CBME_CYC_PM_READ;
      cbme_pkg::OP_PM_WRITE: op_cycles = PM_WRITE_CYCLES;
      cbme_pkg::OP_PUSH, cbme_pkg::OP_POP: op_cycles = `CBME_CYC_STACK;
      cbme_pkg::OP_IO_BIT_SET, cbme_pkg::OP_IO_BIT_CLEAR: op_cycles = `CBME_CYC_IO_BIT;
      default: op_cycles = `CBME_CYC_SINGLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operand views and register read mux
  always_comb begin
    zp = {q.regs[31], q.regs[30]};
    pmw = q.pm[zp[PMW:1]];
    pmb = zp[0] ? pmw[15:8] : pmw[7:0];
    src = q.regs[q.rd];
    issue_op = cbme_pkg::cbme_op_type'(HWDATA[`CBME_CMD_OP_LSB +: 5]);
    rdmux = 32'h00000000;
    if (q.hit) begin
      case (q.addr)
        `CBME_ADDR_CMD: rdmux = {13'h0, q.bsel, q.ioa, q.rd, q.op};
        `CBME_ADDR_STATUS: rdmux = {30'h0, q.sleep, q.st == cbme_pkg::ST_EXEC};
        `CBME_ADDR_FLAGS: rdmux = {24'h000000, q.flags};
        `CBME_ADDR_REG_SEL: rdmux = {27'h0, q.reg_sel};
        `CBME_ADDR_REG_DATA: rdmux = {24'h000000, q.regs[q.reg_sel]};
        `CBME_ADDR_IO_SEL: rdmux = {{(32 - IOW){1'b0}}, q.io_sel};
        `CBME_ADDR_IO_DATA: rdmux = {24'h000000, q.io[q.io_sel]};
        `CBME_ADDR_PM_SEL: rdmux = {{(32 - PMW){1'b0}}, q.pm_sel};
        `CBME_ADDR_PM_DATA: rdmux = {16'h0000, q.pm[q.pm_sel]};
        `CBME_ADDR_STACK_PTR: rdmux = {{(32 - SPW){1'b0}}, q.sp};
        `CBME_ADDR_WDR_COUNT: rdmux = {16'h0000, q.wdr_cnt};
        default: rdmux = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, sequencer, execution
  always_comb begin
    n = q;
    n.done = 1'b0;
    n.watchdog_restart = 1'b0;
    issue = 1'b0;
    commit = 1'b0;
    sh = 8'h00;
    shc = 1'b0;
    is_sh = 1'b0;
    // reads always take one wait state so the data comes from a flop
    if (q.rd_pend && !q.rd_done) begin
      n.hrdata = rdmux;
      n.rd_done = 1'b1;
    end
    if (WAKE) begin
      n.sleep = 1'b0;
    end
    // write data phase; data registers are frozen while an operation runs
    if (HREADY && q.wr_pend && q.hit) begin
      case (q.addr)
        `CBME_ADDR_CMD: begin
          if (q.st == cbme_pkg::ST_IDLE) begin
            issue = 1'b1;
            n.op = issue_op;
            n.rd = HWDATA[`CBME_CMD_RD_LSB +: 5];
            n.ioa = HWDATA[`CBME_CMD_IOA_LSB +: 6];
            n.bsel = HWDATA[`CBME_CMD_BIT_LSB +: 3];
            n.cnt = op_cycles(issue_op);
            n.st = cbme_pkg::ST_EXEC;
          end
        end
        `CBME_ADDR_STATUS: begin
          if (HWDATA[`CBME_STAT_SLEEP]) begin
            n.sleep = 1'b0;
          end
        end
        `CBME_ADDR_FLAGS: n.flags = HWDATA[7:0];
        `CBME_ADDR_REG_SEL: n.reg_sel = HWDATA[4:0];
        `CBME_ADDR_IO_SEL: n.io_sel = HWDATA[IOW-1:0];
        `CBME_ADDR_PM_SEL: n.pm_sel = HWDATA[PMW-1:0];
        default: begin
          if (q.st == cbme_pkg::ST_IDLE) begin
            if (q.addr == `CBME_ADDR_REG_DATA) n.regs[q.reg_sel] = HWDATA[7:0];
            if (q.addr == `CBME_ADDR_IO_DATA) n.io[q.io_sel] = HWDATA[7:0];
            if (q.addr == `CBME_ADDR_PM_DATA) n.pm[q.pm_sel] = HWDATA[15:0];
            if (q.addr == `CBME_ADDR_STACK_PTR) n.sp = HWDATA[SPW-1:0];
          end
        end
      endcase
    end
    // address phase capture
    if (HREADY) begin
      n.wr_pend = HSEL && HTRANS[1] && HWRITE;
      n.rd_pend = HSEL && HTRANS[1] && !HWRITE;
      n.rd_done = 1'b0;
      n.hit = HADDR[31:8] == 24'h000000;
      n.addr = HADDR[7:0];
    end
    // sequencer counts the documented cycles, then commits
    unique case (q.st)
      cbme_pkg::ST_IDLE: begin
      end
      cbme_pkg::ST_EXEC: begin
        n.cnt = q.cnt - 8'h01;
        if (q.cnt == 8'h01) begin
          commit = 1'b1;
          n.done = 1'b1;
          n.st = cbme_pkg::ST_IDLE;
        end
      end
    endcase
    if (commit) begin
      case (q.op)
        cbme_pkg::OP_PM_READ_R0: n.regs[0] = pmb; // RULE1
        cbme_pkg::OP_PM_READ: n.regs[q.rd] = pmb; // RULE1
        cbme_pkg::OP_PM_READ_INC: begin
          n.regs[q.rd] = pmb; // RULE1
          {n.regs[31], n.regs[30]} = zp + 16'h0001; // RULE1
        end
        cbme_pkg::OP_PM_WRITE: n.pm[zp[PMW:1]] = {q.regs[1], q.regs[0]}; // RULE15
        cbme_pkg::OP_PORT_IN: n.regs[q.rd] = q.io[q.ioa[IOW-1:0]]; // RULE16
        cbme_pkg::OP_PORT_OUT: n.io[q.ioa[IOW-1:0]] = src; // RULE16
        cbme_pkg::OP_PUSH: begin
          n.stk[q.sp] = src; // RULE2
          n.sp = q.sp - SP_ONE; // RULE2
        end
        cbme_pkg::OP_POP: begin
          n.sp = q.sp + SP_ONE; // RULE3
          n.regs[q.rd] = q.stk[q.sp + SP_ONE]; // RULE3
        end
        cbme_pkg::OP_IO_BIT_SET: n.io[q.ioa[IOW-1:0]][q.bsel] = 1'b1; // RULE4
        cbme_pkg::OP_IO_BIT_CLEAR: n.io[q.ioa[IOW-1:0]][q.bsel] = 1'b0; // RULE4
        cbme_pkg::OP_SHL_LOGICAL: {is_sh, shc, sh} = {1'b1, src[7], src[6:0], 1'b0}; // RULE14
        cbme_pkg::OP_SHR_LOGICAL: {is_sh, shc, sh} = {1'b1, src[0], 1'b0, src[7:1]}; // RULE14
        cbme_pkg::OP_SHR_ARITH: {is_sh, shc, sh} = {1'b1, src[0], src[7], src[7:1]}; // RULE14
        cbme_pkg::OP_ROT_LEFT_CARRY: {is_sh, shc, sh} = {1'b1, src[7], src[6:0], q.flags[`CBME_FLAG_C]}; // RULE5
        cbme_pkg::OP_ROT_RIGHT_CARRY: {is_sh, shc, sh} = {1'b1, src[0], q.flags[`CBME_FLAG_C], src[7:1]}; // RULE6
        cbme_pkg::OP_BIT_TO_TFLAG: n.flags[`CBME_FLAG_T] = src[q.bsel]; // RULE7
        cbme_pkg::OP_TFLAG_TO_BIT: n.regs[q.rd][q.bsel] = q.flags[`CBME_FLAG_T]; // RULE8
        cbme_pkg::OP_SIGNED_SET: n.flags[`CBME_FLAG_S] = 1'b1; // RULE9
        cbme_pkg::OP_SIGNED_CLEAR: n.flags[`CBME_FLAG_S] = 1'b0; // RULE9
        cbme_pkg::OP_OVF_SET: n.flags[`CBME_FLAG_V] = 1'b1; // RULE10
        cbme_pkg::OP_OVF_CLEAR: n.flags[`CBME_FLAG_V] = 1'b0; // RULE10
        cbme_pkg::OP_HALF_SET: n.flags[`CBME_FLAG_H] = 1'b1; // RULE11
        cbme_pkg::OP_HALF_CLEAR: n.flags[`CBME_FLAG_H] = 1'b0; // RULE11
        cbme_pkg::OP_SLEEP: n.sleep = 1'b1; // RULE12
        cbme_pkg::OP_WDOG_RESTART: begin
          n.watchdog_restart = 1'b1; // RULE13
          n.wdr_cnt = q.wdr_cnt + 16'h0001;
        end
        default: begin
        end
      endcase
      // shifts and rotates share one flag update; S is left alone
      if (is_sh) begin
        n.regs[q.rd] = sh;
        n.flags[`CBME_FLAG_Z] = sh == 8'h00;
        n.flags[`CBME_FLAG_C] = shc;
        n.flags[`CBME_FLAG_N] = sh[7];
        n.flags[`CBME_FLAG_V] = sh[7] ^ shc;
      end
    end
    if (SRST) begin
      n = '0;
      n.st = cbme_pkg::ST_IDLE;
      n.sp = SP_TOP;
      n.flags = `CBME_FLAGS_RESET;
    end
  end

  // single state register
  always_ff @(posedge CLK) begin
    q <= n;
  end

  // outputs
  assign HRDATA = q.hrdata;
  assign HREADYOUT = !(q.rd_pend && !q.rd_done);
  assign HRESP = 1'b0;
  assign SLEEP_REQ = q.sleep;
  assign WDT_RESTART = q.watchdog_restart;
  assign EXEC_DONE = q.done;
  assign BUSY = q.st == cbme_pkg::ST_EXEC;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence done_after_2;
    (!q.done)[*2] ##1 q.done;
  endsequence
  sequence done_after_3;
    (!q.done)[*3] ##1 q.done;
  endsequence
  // issue is seen at the accepting edge; done rises one edge after commit, so count from the next edge
  pm_read_time_a: assert property (issue && issue_op == cbme_pkg::OP_PM_READ |=> done_after_3) // RULE1
    else $error("program memory read not done in 3 cycles");
  pm_read_inc_a: assert property (commit && q.op == cbme_pkg::OP_PM_READ_INC |=> // RULE1
    zp == $past(zp) + 16'h0001 && q.flags == $past(q.flags)) else $error("z increment or flags wrong");
  push_time_a: assert property (issue && issue_op == cbme_pkg::OP_PUSH |=> done_after_2) // RULE2
    else $error("push not done in 2 cycles");
  pop_stack_a: assert property (commit && q.op == cbme_pkg::OP_POP |=> // RULE3
    q.sp == $past(q.sp) + SP_ONE && q.flags == $past(q.flags)) else $error("pop pointer or flags wrong");
  io_bit_time_a: assert property (issue && issue_op == cbme_pkg::OP_IO_BIT_SET |=> done_after_2) // RULE4
    else $error("io bit set not done in 2 cycles");
  rotate_left_a: assert property (commit && q.op == cbme_pkg::OP_ROT_LEFT_CARRY |=> // RULE5
    q.flags[`CBME_FLAG_C] == $past(src[7]) && q.regs[$past(q.rd)][0] == $past(q.flags[`CBME_FLAG_C]))
    else $error("rotate left carry wrong");
  rotate_right_a: assert property (commit && q.op == cbme_pkg::OP_ROT_RIGHT_CARRY |=> // RULE6
    q.flags[`CBME_FLAG_C] == $past(src[0]) && q.regs[$past(q.rd)][7] == $past(q.flags[`CBME_FLAG_C]))
    else $error("rotate right carry wrong");
  tflag_copy_a: assert property (commit && q.op == cbme_pkg::OP_BIT_TO_TFLAG |=> // RULE7
    q.flags[`CBME_FLAG_T] == $past(src[q.bsel])) else $error("transfer flag not copied");
  signed_set_a: assert property (commit && q.op == cbme_pkg::OP_SIGNED_SET |=> // RULE9
    q.flags == ($past(q.flags) | 8'h10)) else $error("signed flag set wrong");
  ovf_clear_a: assert property (commit && q.op == cbme_pkg::OP_OVF_CLEAR |=> // RULE10
    q.flags == ($past(q.flags) & 8'hf7)) else $error("overflow clear wrong");
  half_set_a: assert property (commit && q.op == cbme_pkg::OP_HALF_SET |=> // RULE11
    q.flags == ($past(q.flags) | 8'h20)) else $error("half carry set wrong");
  sleep_enter_a: assert property (issue && issue_op == cbme_pkg::OP_SLEEP && !WAKE |=> // RULE12
    ##1 (SLEEP_REQ || $past(WAKE))) else $error("sleep not entered");
  wdog_pulse_a: assert property (issue && issue_op == cbme_pkg::OP_WDOG_RESTART |=> // RULE13
    !WDT_RESTART ##1 WDT_RESTART ##1 !WDT_RESTART) else $error("watchdog restart pulse wrong");
  shr_logic_a: assert property (commit && q.op == cbme_pkg::OP_SHR_LOGICAL |=> // RULE14
    q.regs[$past(q.rd)][7] == 1'b0 && q.flags[`CBME_FLAG_C] == $past(src[0])) else $error("logical shift wrong");
endmodule
`default_nettype wire

// ---- cbme_core_model.sv ----
// core-side model: wakes a sleeping core and counts watchdog restarts
`timescale 1ns/10ps
`default_nettype none
module cbme_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // core controls
  input wire logic sleep_req,
  input wire logic wdt_restart,
  input wire logic [3:0] wake_delay,
  output logic wake,
  output logic [7:0] restarts
);
  logic [3:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////////
  // wake comes a programmable time into a sleep, so both prompt and slow wakes occur
  always_ff @(posedge clk) begin
    if (srst || !sleep_req) begin
      wait_q <= 4'h0;
      wake <= 1'b0;
    end else if (wait_q == wake_delay) begin
      wake <= 1'b1; // held until the request drops
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // each one-cycle restart pulse is one restart of the watchdog
  always_ff @(posedge clk) begin
    if (srst) begin
      restarts <= 8'h00;
    end else if (wdt_restart) begin
      restarts <= restarts + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench of the exec unit, driven over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "cbme_regs.svh"
module tb_top;
  logic CLK, SRST, HSEL, HWRITE, WAKE, HREADYOUT, HRESP, SLEEP_REQ, WDT_RESTART, EXEC_DONE, BUSY;
  logic [31:0] HADDR, HWDATA, HRDATA, rv;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [3:0] wake_delay;
  logic [7:0] restarts;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // the one slave's ready is the bus ready
  cbme_exec #(.PM_WRITE_CYCLES(8'h05)) DUT (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WAKE(WAKE), .SLEEP_REQ(SLEEP_REQ),
    .WDT_RESTART(WDT_RESTART), .EXEC_DONE(EXEC_DONE), .BUSY(BUSY));
  cbme_core_model core (.clk(CLK), .srst(SRST), .sleep_req(SLEEP_REQ), .wdt_restart(WDT_RESTART),
    .wake_delay(wake_delay), .wake(WAKE), .restarts(restarts));
  // clock of 40 ns
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // a hang is cut short well past the expected run length
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // address phase held until ready, then the bus goes idle for the data phase
  task automatic ahb_addr(input logic [7:0] a, input logic w);
    @(posedge CLK);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'b10;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
  endtask
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    ahb_addr(a, 1'b1);
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] q);
    ahb_addr(a, 1'b0);
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  // indexed spaces (registers, i/o, program memory) go through a select and a data word
  task automatic wmem(input logic [7:0] sa, input logic [7:0] da, input logic [31:0] i, input logic [31:0] v);
    ahb_wr(sa, i);
    ahb_wr(da, v);
  endtask
  task automatic cmem(input logic [7:0] sa, input logic [7:0] da, input logic [31:0] i, input logic [31:0] e);
    ahb_wr(sa, i);
    ahb_rd(da, rv);
    chk("indexed word", e, rv);
  endtask
  task automatic cflags(input logic [7:0] e);
    ahb_rd(`CBME_ADDR_FLAGS, rv);
    chk("flags", {24'h0, e}, rv);
    chk("response", 32'h0, HRESP);
  endtask
  // issues one operation and counts edges from acceptance until done is seen
  task automatic run_op(input logic [4:0] op, input logic [4:0] rd, input logic [5:0] ioa,
    input logic [2:0] bt, input int n);
    int k;
    k = 0;
    ahb_wr(`CBME_ADDR_CMD, {13'h0, bt, ioa, rd, op});
    // the command is taken at the edge that ends its data phase, so busy is up just after it
    #1;
    chk("busy", 32'h1, BUSY);
    do begin
      @(posedge CLK);
      #1;
      k++;
    end while (EXEC_DONE !== 1'b1 && k < 40);
    chk("op cycles", n, k);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // shifts and rotates with carry in set, then a result of zero
  task automatic t_shifts;
    logic [4:0] ops [6] = '{cbme_pkg::OP_SHL_LOGICAL, cbme_pkg::OP_SHR_LOGICAL, cbme_pkg::OP_SHR_ARITH,
      cbme_pkg::OP_ROT_LEFT_CARRY, cbme_pkg::OP_ROT_RIGHT_CARRY, cbme_pkg::OP_SHR_LOGICAL};
    logic [7:0] vin [6] = '{8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h01};
    logic [7:0] fin [6] = '{8'h31, 8'h31, 8'h31, 8'h31, 8'h31, 8'h00};
    logic [7:0] vout [6] = '{8'h02, 8'h40, 8'hc0, 8'h03, 8'hc0, 8'h00};
    logic [7:0] fout [6] = '{8'h39, 8'h39, 8'h35, 8'h39, 8'h35, 8'h0b};
    for (int i = 0; i < 6; i++) begin
      wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 16, vin[i]);
      ahb_wr(`CBME_ADDR_FLAGS, fin[i]);
      run_op(ops[i], 5'd16, 6'd0, 3'd0, 1);
      cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 16, vout[i]);
      cflags(fout[i]);
    end
  endtask
  // S, V and H each set from all clear and each cleared from all set, then the transfer flag both ways
  task automatic t_flags;
    logic [7:0] fin [6] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
    logic [7:0] fout [6] = '{8'h10, 8'hef, 8'h08, 8'hf7, 8'h20, 8'hdf};
    for (int i = 0; i < 6; i++) begin
      ahb_wr(`CBME_ADDR_FLAGS, fin[i]);
      run_op(5'(cbme_pkg::OP_SIGNED_SET + i), 5'd0, 6'd0, 3'd0, 1);
      cflags(fout[i]);
    end
    ahb_wr(`CBME_ADDR_FLAGS, 32'h0);
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 16, 32'h20);
    run_op(cbme_pkg::OP_BIT_TO_TFLAG, 5'd16, 6'd0, 3'd5, 1);
    cflags(8'h40);
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 17, 32'h0);
    run_op(cbme_pkg::OP_TFLAG_TO_BIT, 5'd17, 6'd0, 3'd2, 1);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 17, 32'h04);
    cflags(8'h40);
  endtask
  // program memory reads in all three forms, then a write of r1:r0
  task automatic t_pm;
    wmem(`CBME_ADDR_PM_SEL, `CBME_ADDR_PM_DATA, 5, 32'hbeef);
    wmem(`CBME_ADDR_PM_SEL, `CBME_ADDR_PM_DATA, 6, 32'h1234);
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 30, 32'h0b);
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 31, 32'h00);
    ahb_wr(`CBME_ADDR_FLAGS, 32'h2a);
    run_op(cbme_pkg::OP_PM_READ_INC, 5'd16, 6'd0, 3'd0, 3);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 16, 32'hbe);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 30, 32'h0c);
    run_op(cbme_pkg::OP_PM_READ_R0, 5'd9, 6'd0, 3'd0, 3);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 0, 32'h34);
    run_op(cbme_pkg::OP_PM_READ, 5'd17, 6'd0, 3'd0, 3);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 17, 32'h34);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 30, 32'h0c);
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 1, 32'h56);
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 0, 32'h78);
    run_op(cbme_pkg::OP_PM_WRITE, 5'd0, 6'd0, 3'd0, 5);
    cmem(`CBME_ADDR_PM_SEL, `CBME_ADDR_PM_DATA, 6, 32'h5678);
    cflags(8'h2a);
  endtask
  // push then pop into another register; a command sent while busy is dropped
  task automatic t_stack;
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 5, 32'ha5);
    run_op(cbme_pkg::OP_PUSH, 5'd5, 6'd0, 3'd0, 2);
    ahb_rd(`CBME_ADDR_STACK_PTR, rv);
    chk("stack pointer", 32'd14, rv);
    run_op(cbme_pkg::OP_POP, 5'd7, 6'd0, 3'd0, 2);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 7, 32'ha5);
    cflags(8'h2a);
    ahb_wr(`CBME_ADDR_CMD, {27'h0, cbme_pkg::OP_PM_WRITE});
    ahb_wr(`CBME_ADDR_CMD, {22'h0, 5'd5, cbme_pkg::OP_PUSH});
    repeat (8) @(posedge CLK);
    ahb_rd(`CBME_ADDR_STACK_PTR, rv);
    chk("stack pointer", 32'd15, rv);
  endtask
  // single i/o bits forced at both ends of the byte, then port moves
  task automatic t_io;
    wmem(`CBME_ADDR_IO_SEL, `CBME_ADDR_IO_DATA, 10, 32'h0);
    run_op(cbme_pkg::OP_IO_BIT_SET, 5'd0, 6'd10, 3'd7, 2);
    run_op(cbme_pkg::OP_IO_BIT_SET, 5'd0, 6'd10, 3'd0, 2);
    cmem(`CBME_ADDR_IO_SEL, `CBME_ADDR_IO_DATA, 10, 32'h81);
    run_op(cbme_pkg::OP_IO_BIT_CLEAR, 5'd0, 6'd10, 3'd7, 2);
    cmem(`CBME_ADDR_IO_SEL, `CBME_ADDR_IO_DATA, 10, 32'h01);
    wmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 8, 32'h5a);
    run_op(cbme_pkg::OP_PORT_OUT, 5'd8, 6'd20, 3'd0, 1);
    cmem(`CBME_ADDR_IO_SEL, `CBME_ADDR_IO_DATA, 20, 32'h5a);
    run_op(cbme_pkg::OP_PORT_IN, 5'd9, 6'd10, 3'd0, 1);
    cmem(`CBME_ADDR_REG_SEL, `CBME_ADDR_REG_DATA, 9, 32'h01);
    cflags(8'h2a);
  endtask
  // sleep left by a prompt wake and by a status write, watchdog restart, no-ops, unmapped read
  task automatic t_ctrl;
    int k;
    run_op(cbme_pkg::OP_SLEEP, 5'd0, 6'd0, 3'd0, 1);
    chk("sleep request", 32'h1, SLEEP_REQ);
    k = 0;
    while (SLEEP_REQ !== 1'b0 && k < 20) begin
      @(posedge CLK);
      k++;
    end
    chk("sleep cleared by wake", 32'h1, k < 20);
    wake_delay <= 4'hf;
    run_op(cbme_pkg::OP_SLEEP, 5'd0, 6'd0, 3'd0, 1);
    ahb_rd(`CBME_ADDR_STATUS, rv);
    chk("status", 32'h2, rv);
    ahb_wr(`CBME_ADDR_STATUS, 32'h2);
    @(posedge CLK);
    chk("sleep request", 32'h0, SLEEP_REQ);
    run_op(cbme_pkg::OP_WDOG_RESTART, 5'd0, 6'd0, 3'd0, 1);
    // the model counts the pulse one edge after it appears, so look after the read
    ahb_rd(`CBME_ADDR_WDR_COUNT, rv);
    chk("restart pulses", 32'h1, restarts);
    chk("restart count", 32'h1, rv);
    run_op(cbme_pkg::OP_NOP, 5'd0, 6'd0, 3'd0, 1);
    run_op(5'h1f, 5'd0, 6'd0, 3'd0, 1);
    cflags(8'h2a);
    ahb_rd(8'h80, rv);
    chk("unmapped read", 32'h0, rv);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset for 20 cycles, then each scenario in turn
  initial begin
    SRST = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    wake_delay = 4'h3;
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    cflags(`CBME_FLAGS_RESET);
    t_shifts;
    t_flags;
    t_pm;
    t_stack;
    t_io;
    t_ctrl;
    finish_test;
  end
endmodule
`default_nettype wire
